// ### core/svul_pkg.sv
// Summary of operation
// R1: Function 18H selects update; feature bit 10.
// R2: Cache ready only with no valid pages.
// R3: Success loads microcode version, makes new keys.
// R4: Fail on busy leaf, unready cache, low entropy.
// R5: Any failure sets zero flag plus code.
// R6: Version already current sets carry flag.
// R7: Code 0 success, 7 conflict, checked first.
// R8: Code 29 on insufficient random entropy.
// R9: Code 30 unready cache, after conflict check.
// R10: Code 31 when version unchanged after commit.
// R11: Draw 512 random bits before commit.
// R12: Paging leaves in progress also conflict.
// R13: Keep 16-byte copy of old version.
// R14: Hold new key in 64-byte store.
// R15: Software keeps other leaves idle meanwhile.
// R16: Other leaf during update may fault.
// R17: Software retries after low entropy.
// R18: Software removes all pages beforehand.
// R19: Software traps leaf for foreign guests.
// R20: Base key low half, report key high.
package svul_pkg;

  localparam logic [7:0] LEAF_FUNC            = 8'h18;
  localparam int         FEATURE_BIT          = 10;

  localparam logic [7:0] SUCCESS_CODE         = 8'h00;
  localparam logic [7:0] ACCESS_CONFLICT_CODE = 8'h07;
  localparam logic [7:0] LOW_ENTROPY_CODE     = 8'h1d;
  localparam logic [7:0] CACHE_NOT_READY_CODE = 8'h1e;
  localparam logic [7:0] VERSION_UNCHANGED_CODE = 8'h1f;

  localparam int VERSION_BYTES   = 16;
  localparam int KEY_BYTES       = 64;
  localparam int VERSION_BITS    = VERSION_BYTES * 8;
  localparam int KEY_BITS        = KEY_BYTES * 8;
  localparam int BASE_KEY_BITS   = 256;
  localparam int RNG_WORD_BITS   = 64;
  localparam int PAGE_COUNT_BITS = 16;

  localparam int                 AXI_ADDR_BITS = 8;
  localparam logic [7:0]         OFS_FUNC      = 8'h00;
  localparam logic [7:0]         OFS_STATUS    = 8'h04;
  localparam logic [7:0]         OFS_RESULT    = 8'h08;
  localparam logic [7:0]         OFS_FEATURE   = 8'h0c;
  localparam logic [7:0]         OFS_VERSION   = 8'h10;
  localparam logic [7:0]         VERSION_MASK  = 8'hf3;

  localparam int STS_BUSY = 0;
  localparam int STS_ZF   = 1;
  localparam int STS_CF   = 2;
  localparam int STS_DONE = 3;

  localparam logic [31:0]              FUNC_RST    = 32'h0000_0000;
  localparam logic [VERSION_BITS-1:0]  VERSION_RST = 128'h0;
  localparam logic [BASE_KEY_BITS-1:0] KEY_RST     = 256'h0;
  localparam logic [1:0]               RESP_OKAY   = 2'b00;
  localparam logic [1:0]               RESP_DECERR = 2'b11;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_KEYGEN = 3'b010,
    ST_COMMIT = 3'b011,
    ST_DECIDE = 3'b100
  } svul_state_e;

  typedef struct packed {
    logic       zero_flag;
    logic       carry_flag;
    logic [7:0] code;
  } svul_result_s;

  localparam svul_result_s RESULT_RST = '{zero_flag: 1'b0, carry_flag: 1'b0, code: 8'h00};

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ### core/svul_key_gather.sv
`timescale 1ns/10ps
// Collects random words into the pending paging key
module svul_key_gather #(
  parameter int WORD_W = svul_pkg::RNG_WORD_BITS,
  parameter int KEY_W  = svul_pkg::KEY_BITS
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              start,
  input  wire logic              rng_valid,
  input  wire logic [WORD_W-1:0] rng_data,
  input  wire logic              rng_low_entropy,
  output logic                   rng_req,
  output logic [KEY_W-1:0]       pending_key,
  output logic                   done,
  output logic                   fail
);
  localparam int WORDS = KEY_W / WORD_W;
  localparam int CNT_W = $clog2(WORDS + 1);

  logic             active_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [KEY_W-1:0] key_ff;
  logic             done_ff;
  logic             fail_ff;

  wire logic take      = active_ff && rng_valid;
  wire logic last_word = (cnt_ff == CNT_W'(WORDS - 1));

  assign rng_req     = active_ff;
  assign pending_key = key_ff;
  assign done        = done_ff;
  assign fail        = fail_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_ff <= 1'b0;
      cnt_ff    <= '0;
      key_ff    <= '0;
      done_ff   <= 1'b0;
      fail_ff   <= 1'b0;
    end else begin
      done_ff <= take && !rng_low_entropy && last_word;
      fail_ff <= take && rng_low_entropy;
      if (start) begin
        active_ff <= 1'b1;
        cnt_ff    <= '0;
      end else if (take) begin
        active_ff <= !rng_low_entropy && !last_word;
        cnt_ff    <= cnt_ff + 1'b1;
      end
      if (take && !rng_low_entropy) begin
        key_ff <= {rng_data, key_ff[KEY_W-1:WORD_W]}; // R14
      end
    end
  end
endmodule

// ### core/svul_page_tracker.sv
`timescale 1ns/10ps
// Counts valid pages of the enclave page cache
module svul_page_tracker #(
  parameter int COUNT_W = svul_pkg::PAGE_COUNT_BITS
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic page_mark_valid,
  input  wire logic page_mark_unused,
  output logic      cache_ready
);
  logic [COUNT_W-1:0] count_ff;

  wire logic up   = page_mark_valid && !page_mark_unused && !(&count_ff);
  wire logic down = page_mark_unused && !page_mark_valid && (count_ff != '0);

  assign cache_ready = (count_ff == '0); // R2

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else if (up) begin
      count_ff <= count_ff + 1'b1;
    end else if (down) begin
      count_ff <= count_ff - 1'b1;
    end
  end
endmodule

// ### core/svul_top.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
// Version update leaf with an AXI4-Lite register slave
module svul_top (
  input  wire logic                                aclk,
  input  wire logic                                aresetn,
  input  wire logic [svul_pkg::AXI_ADDR_BITS-1:0]  awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  input  wire logic [svul_pkg::AXI_ADDR_BITS-1:0]  araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  input  wire logic                                priv_leaf_active,
  input  wire logic                                paging_leaf_active,
  input  wire logic                                page_mark_valid,
  input  wire logic                                page_mark_unused,
  input  wire logic [svul_pkg::VERSION_BITS-1:0]   ucode_version,
  output logic                                     rng_req,
  input  wire logic                                rng_valid,
  input  wire logic [svul_pkg::RNG_WORD_BITS-1:0]  rng_data,
  input  wire logic                                rng_low_entropy,
  input  wire logic                                other_leaf_issue,
  output logic                                     update_busy,
  output logic                                     gp_fault,
  output logic [svul_pkg::BASE_KEY_BITS-1:0]       base_key,
  output logic [svul_pkg::BASE_KEY_BITS-1:0]       report_auth_key,
  output logic [svul_pkg::VERSION_BITS-1:0]        internal_security_version
);
  localparam int KB = svul_pkg::KEY_BITS;
  localparam int BB = svul_pkg::BASE_KEY_BITS;
  localparam int VB = svul_pkg::VERSION_BITS;

  // Write and read channel registers, function register
  logic                              aw_held_ff;
  logic [svul_pkg::AXI_ADDR_BITS-1:0] aw_addr_ff;
  logic                              w_held_ff;
  logic [31:0]                       w_data_ff;
  logic [3:0]                        w_strb_ff;
  logic                              bvalid_ff;
  logic [1:0]                        bresp_ff;
  logic                              rvalid_ff;
  logic [31:0]                       rdata_ff;
  logic [1:0]                        rresp_ff;
  logic [31:0]                       func_ff;

  // Leaf state
  svul_pkg::svul_state_e  state_ff;
  svul_pkg::svul_state_e  nxt_state;
  svul_pkg::svul_result_s result_ff;
  svul_pkg::svul_result_s nxt_result;
  logic                   done_ff;
  logic                   nxt_done;
  logic [VB-1:0]          saved_version_copy_ff;
  logic [VB-1:0]          internal_version_ff;
  logic [BB-1:0]          base_key_ff;
  logic [BB-1:0]          report_key_ff;
  logic                   gp_fault_ff;

  logic          cache_ready;
  logic [KB-1:0] pending_key;
  logic          key_done;
  logic          key_fail;

  wire logic aw_take = awvalid && awready;
  wire logic w_take  = wvalid && wready;
  wire logic have_aw = aw_held_ff || aw_take;
  wire logic have_w  = w_held_ff || w_take;
  wire logic wr_fire = have_aw && have_w;

  wire logic [svul_pkg::AXI_ADDR_BITS-1:0] wr_addr = aw_held_ff ? aw_addr_ff : awaddr;
  wire logic [31:0] wr_data = w_held_ff ? w_data_ff : wdata;
  wire logic [3:0]  wr_strb = w_held_ff ? w_strb_ff : wstrb;

  wire logic busy       = (state_ff != svul_pkg::ST_IDLE);
  wire logic conflict   = priv_leaf_active || paging_leaf_active;
  wire logic func_wr    = wr_fire && (wr_addr == svul_pkg::OFS_FUNC);
  wire logic start      = func_wr && !busy && wr_strb[0] &&
                          (wr_data[7:0] == svul_pkg::LEAF_FUNC); // R1
  wire logic version_hit_w = ((wr_addr & svul_pkg::VERSION_MASK) == svul_pkg::OFS_VERSION);
  wire logic wr_mapped  = (wr_addr == svul_pkg::OFS_FUNC) || (wr_addr == svul_pkg::OFS_STATUS) ||
                          (wr_addr == svul_pkg::OFS_RESULT) ||
                          (wr_addr == svul_pkg::OFS_FEATURE) || version_hit_w;
  wire logic key_start  = (state_ff == svul_pkg::ST_CHECK) && (nxt_state == svul_pkg::ST_KEYGEN);
  wire logic versions_equal = (saved_version_copy_ff == internal_version_ff);

  // Read decode
  wire logic ar_take       = arvalid && arready;
  wire logic version_hit_r = ((araddr & svul_pkg::VERSION_MASK) == svul_pkg::OFS_VERSION);
  wire logic [31:0] status_word = {28'h0, done_ff, result_ff.carry_flag,
                                   result_ff.zero_flag, busy};
  wire logic [31:0] version_word = internal_version_ff[araddr[3:2]*32 +: 32];
  wire logic [31:0] feature_word = 32'h1 << svul_pkg::FEATURE_BIT; // R1
  wire logic rd_mapped = (araddr == svul_pkg::OFS_FUNC) || (araddr == svul_pkg::OFS_STATUS) ||
                         (araddr == svul_pkg::OFS_RESULT) || (araddr == svul_pkg::OFS_FEATURE) ||
                         version_hit_r;
  wire logic [31:0] rd_mux =
    (araddr == svul_pkg::OFS_FUNC)    ? func_ff :
    (araddr == svul_pkg::OFS_STATUS)  ? status_word :
    (araddr == svul_pkg::OFS_RESULT)  ? {24'h0, result_ff.code} :
    (araddr == svul_pkg::OFS_FEATURE) ? feature_word :
    version_hit_r                     ? version_word : 32'h0;

  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready  = !w_held_ff && !bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = !rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  assign update_busy               = busy; // R15
  assign gp_fault                  = gp_fault_ff;
  assign base_key                  = base_key_ff;
  assign report_auth_key           = report_key_ff;
  assign internal_security_version = internal_version_ff;

  svul_page_tracker u_page_tracker (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .page_mark_valid  (page_mark_valid),
    .page_mark_unused (page_mark_unused),
    .cache_ready      (cache_ready)
  );

  svul_key_gather u_key_gather (
    .aclk            (aclk),
    .aresetn         (aresetn),
    .start           (key_start),
    .rng_valid       (rng_valid),
    .rng_data        (rng_data),
    .rng_low_entropy (rng_low_entropy),
    .rng_req         (rng_req),
    .pending_key     (pending_key),
    .done            (key_done),
    .fail            (key_fail)
  );

  // Leaf sequence: conflict, readiness, key draw, commit, decide
  always_comb begin
    nxt_state  = state_ff;
    nxt_result = result_ff;
    nxt_done   = done_ff;
    unique case (state_ff)
      svul_pkg::ST_IDLE: begin
        if (start) begin
          nxt_state  = svul_pkg::ST_CHECK;
          nxt_result = svul_pkg::RESULT_RST;
          nxt_done   = 1'b0;
        end
      end
      svul_pkg::ST_CHECK: begin
        if (conflict) begin // R4 R7 R12
          nxt_state  = svul_pkg::ST_IDLE;
          nxt_result = '{1'b1, 1'b0, svul_pkg::ACCESS_CONFLICT_CODE}; // R5
          nxt_done   = 1'b1;
        end else if (!cache_ready) begin // R9
          nxt_state  = svul_pkg::ST_IDLE;
          nxt_result = '{1'b1, 1'b0, svul_pkg::CACHE_NOT_READY_CODE}; // R5
          nxt_done   = 1'b1;
        end else begin
          nxt_state = svul_pkg::ST_KEYGEN; // R11
        end
      end
      svul_pkg::ST_KEYGEN: begin
        if (key_fail) begin // R8
          nxt_state  = svul_pkg::ST_IDLE;
          nxt_result = '{1'b1, 1'b0, svul_pkg::LOW_ENTROPY_CODE}; // R5
          nxt_done   = 1'b1;
        end else if (key_done) begin
          nxt_state = svul_pkg::ST_COMMIT;
        end
      end
      svul_pkg::ST_COMMIT: begin
        nxt_state = svul_pkg::ST_DECIDE;
      end
      svul_pkg::ST_DECIDE: begin
        nxt_state = svul_pkg::ST_IDLE;
        nxt_done  = 1'b1;
        if (versions_equal) begin // R6 R10
          nxt_result = '{1'b0, 1'b1, svul_pkg::VERSION_UNCHANGED_CODE};
        end else begin // R7
          nxt_result = '{1'b0, 1'b0, svul_pkg::SUCCESS_CODE};
        end
      end
      default: begin
        nxt_state = svul_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff  <= svul_pkg::ST_IDLE;
      result_ff <= svul_pkg::RESULT_RST;
      done_ff   <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
    end
  end

  // Commit step and key stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      saved_version_copy_ff <= svul_pkg::VERSION_RST;
      internal_version_ff   <= svul_pkg::VERSION_RST;
      base_key_ff           <= svul_pkg::KEY_RST;
      report_key_ff         <= svul_pkg::KEY_RST;
    end else if (state_ff == svul_pkg::ST_COMMIT) begin
      saved_version_copy_ff <= internal_version_ff; // R13
      internal_version_ff   <= ucode_version; // R3
    end else if (state_ff == svul_pkg::ST_DECIDE && !versions_equal) begin
      base_key_ff   <= pending_key[BB-1:0]; // R3 R20
      report_key_ff <= pending_key[KB-1:BB]; // R20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_fault_ff <= 1'b0;
    end else begin
      gp_fault_ff <= other_leaf_issue && busy; // R16
    end
  end

  // AXI4-Lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_held_ff  <= 1'b0;
      w_data_ff  <= 32'h0;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= svul_pkg::RESP_OKAY;
      func_ff    <= svul_pkg::FUNC_RST;
    end else begin
      if (aw_take) begin
        aw_addr_ff <= awaddr;
      end
      if (w_take) begin
        w_data_ff <= wdata;
        w_strb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? svul_pkg::RESP_OKAY : svul_pkg::RESP_DECERR;
      end else begin
        aw_held_ff <= have_aw;
        w_held_ff  <= have_w;
        if (bvalid_ff && bready) begin
          bvalid_ff <= 1'b0;
        end
      end
      if (func_wr && !busy) begin
        func_ff <= svul_pkg::apply_strb(func_ff, wr_data, wr_strb);
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= svul_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_mapped ? svul_pkg::RESP_OKAY : svul_pkg::RESP_DECERR;
    end else if (rvalid_ff && rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_leaf_select: assert property ( // R1
    start |=> state_ff == svul_pkg::ST_CHECK ##1 state_ff != svul_pkg::ST_CHECK
  ) else $error("leaf start did not enter the check step");

  a_cache_ready: assert property ( // R2
    cache_ready && page_mark_valid && !page_mark_unused |=> !cache_ready
  ) else $error("cache ready despite a valid page");

  a_commit_load: assert property ( // R3
    state_ff == svul_pkg::ST_COMMIT |=> internal_version_ff == $past(ucode_version) &&
                                        saved_version_copy_ff == $past(internal_version_ff)
  ) else $error("commit did not load the version");

  a_conflict_first: assert property ( // R7
    state_ff == svul_pkg::ST_CHECK && conflict |=> state_ff == svul_pkg::ST_IDLE && done_ff &&
      result_ff.zero_flag && result_ff.code == 8'h07
  ) else $error("conflict not reported with code 7");

  a_not_ready: assert property ( // R9
    state_ff == svul_pkg::ST_CHECK && !conflict && !cache_ready |=>
      result_ff.zero_flag && !result_ff.carry_flag && result_ff.code == 8'h1e
  ) else $error("unready cache not reported with code 30");

  a_low_entropy: assert property ( // R8
    state_ff == svul_pkg::ST_KEYGEN && key_fail |=>
      result_ff.zero_flag && result_ff.code == 8'h1d && base_key_ff == $past(base_key_ff)
  ) else $error("entropy failure not reported with code 29");

  a_no_update: assert property ( // R10
    state_ff == svul_pkg::ST_DECIDE && versions_equal |=>
      result_ff.carry_flag && !result_ff.zero_flag && result_ff.code == 8'h1f &&
      $stable(base_key_ff)
  ) else $error("unchanged version not reported with code 31");

  a_key_split: assert property ( // R20
    state_ff == svul_pkg::ST_DECIDE && !versions_equal |=>
      base_key_ff == $past(pending_key[BB-1:0]) && report_key_ff == $past(pending_key[KB-1:BB]) &&
      result_ff.code == 8'h00
  ) else $error("keys not loaded from the new random value");

  a_key_before_commit: assert property ( // R11
    state_ff == svul_pkg::ST_COMMIT |-> $past(state_ff) == svul_pkg::ST_KEYGEN && $past(key_done)
  ) else $error("commit reached without a full key");

  a_fault_other: assert property ( // R16
    other_leaf_issue && busy |=> gp_fault
  ) else $error("other leaf during update did not fault");

endmodule

// ### tb/svul_rng_model.sv
`timescale 1ns/10ps
// Random source: serves the bench key one 64-bit word at a time
module svul_rng_model (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         rng_req,
  input  wire logic         slow,
  input  wire logic         starve,
  input  wire logic [511:0] key,
  output logic              rng_valid,
  output logic [63:0]       rng_data,
  output logic              rng_low_entropy
);
  logic [2:0]  idx_ff;
  logic [63:0] last_ff;
  logic        ph_ff;
  assign rng_valid       = rng_req && (!slow || ph_ff);
  // Idle data is the inverse of the last word so a stale value never matches
  assign rng_data        = rng_valid ? key[idx_ff*64 +: 64] : ~last_ff;
  assign rng_low_entropy = rng_valid && starve;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_ff  <= 3'h0;
      ph_ff   <= 1'b0;
      last_ff <= 64'h0;
    end else begin
      ph_ff <= !ph_ff;
      if (rng_valid) begin
        idx_ff  <= starve ? 3'h0 : idx_ff + 3'h1;
        last_ff <= rng_data;
      end
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rng_req, rng_valid, rng_low_entropy;
  logic prv = 0, pgl = 0, slow = 0, starve = 0;
  logic [2:0] pls = 0;
  logic update_busy, gp_fault;
  logic [63:0] rng_data, seed = 64'd7843;
  logic [127:0] ucode = 0, isv, mver = 0, nver = 0;
  logic [255:0] base_key, rep_key, mbase = 0, mrep = 0;
  logic [511:0] key = 0;
  logic [31:0] rd_d;
  logic [1:0] rd_r, wr_r;
  int miscompares = 0, compares = 0, cycles = 0;
  always #2.5 aclk = ~aclk;
  svul_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .priv_leaf_active(prv), .paging_leaf_active(pgl), .page_mark_valid(pls[0]),
    .page_mark_unused(pls[1]), .ucode_version(ucode), .rng_req(rng_req), .rng_valid(rng_valid),
    .rng_data(rng_data), .rng_low_entropy(rng_low_entropy), .other_leaf_issue(pls[2]),
    .update_busy(update_busy), .gp_fault(gp_fault), .base_key(base_key),
    .report_auth_key(rep_key), .internal_security_version(isv));
  svul_rng_model rng (.aclk(aclk), .aresetn(aresetn), .rng_req(rng_req), .slow(slow),
    .starve(starve), .key(key), .rng_valid(rng_valid), .rng_data(rng_data),
    .rng_low_entropy(rng_low_entropy));
  function automatic logic [63:0] xs(input logic [63:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 7);
    return s ^ (s << 17);
  endfunction
  task automatic summarize();
    if (miscompares == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input string n, input logic [511:0] e, input logic [511:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid;
      wr_r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
    end while (!bh);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(negedge aclk);
      ah = arvalid && arready; rh = rvalid; rd_d = rdata; rd_r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 0;
    end while (!rh);
    rready <= 0;
  endtask
  // Bit 0 marks a page valid, bit 1 removes a page, bit 2 issues another leaf
  task automatic pulse(input int b);
    @(posedge aclk);
    pls[b] <= 1'b1;
    @(posedge aclk);
    pls[b] <= 1'b0;
  endtask
  // Start the leaf, optionally poke another leaf mid-run, then compare the outcome
  task automatic leaf(input int code, input bit zf, input bit cf, input bit poke);
    wr(svul_pkg::OFS_FUNC, 32'h18);
    if (poke) begin
      pulse(2);
      @(negedge aclk);
      chk("gp_fault", 1, gp_fault);
      chk("update_busy", 1, update_busy);
    end
    for (int i = 0; i < 100; i++) begin
      rd(svul_pkg::OFS_STATUS);
      if (rd_d[3] === 1'b1) break;
    end
    chk("status", 8 | (cf << 2) | (zf << 1), rd_d);
    rd(svul_pkg::OFS_RESULT);
    chk("result", code, rd_d);
    chk("version", mver, isv);
    chk("base_key", mbase, base_key);
    chk("report_key", mrep, rep_key);
  endtask
  task automatic fresh();
    seed = xs(seed);
    nver = {seed, ~seed};
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      key[i*64 +: 64] = seed;
    end
  endtask
  initial begin
    fresh();
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(svul_pkg::OFS_FEATURE);
    chk("feature", 32'h400, rd_d);
    rd(8'hfc);
    chk("unmapped_resp", 2'b11, rd_r);
    wr(svul_pkg::OFS_FUNC, 32'h17);
    chk("bresp", 2'b00, wr_r);
    wr(8'hfc, 32'h0);
    chk("unmapped_bresp", 2'b11, wr_r);
    rd(svul_pkg::OFS_STATUS);
    chk("idle_status", 0, rd_d);
    pulse(0);
    for (int i = 1; i < 4; i++) begin
      prv <= i[0];
      pgl <= i[1];
      leaf(7, 1, 0, 0);
    end
    prv <= 0;
    pgl <= 0;
    leaf(30, 1, 0, 0);
    pulse(1);
    starve <= 1;
    leaf(29, 1, 0, 0);
    starve <= 0;
    slow <= 1;
    ucode <= nver;
    mver = nver; mbase = key[255:0]; mrep = key[511:256];
    leaf(0, 0, 0, 1);
    rd(svul_pkg::OFS_VERSION);
    chk("version_word", mver[31:0], rd_d);
    fresh();
    ucode <= mver;
    leaf(31, 0, 1, 0);
    slow <= 0;
    fresh();
    ucode <= nver;
    mver = nver; mbase = key[255:0]; mrep = key[511:256];
    leaf(0, 0, 0, 0);
    summarize();
  end
endmodule
